// >>> hdl/rcs_pkg.sv
// rcs_pkg: constants, types and decode for the comparator sequencer
// assumes one quasi-sinewave period tick per comparison state
package rcs_pkg;

    localparam int         NUM_STATES = 10;
    localparam int         HALF_LEN   = 5;
    localparam logic [9:0] STATE_RST  = 10'h001;
    localparam int         C0 = 0;
    localparam int         C1 = 1;
    localparam int         C2 = 2;
    localparam int         C3 = 3;
    localparam int         C4 = 4;
    localparam int         C5 = 5;
    localparam int         C6 = 6;
    localparam int         C7 = 7;
    localparam int         C8 = 8;
    localparam int         C9 = 9;

    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_SWITCH = 8'h08;
    localparam logic [7:0]  ADDR_CYCLES = 8'h0C;
    localparam int          CTRL_OE_BIT = 0;
    localparam logic        CTRL_OE_RST = 1'b0;
    localparam int          STAT_OE_BIT = 16;
    localparam int          STAT_DIS_BIT = 17;
    localparam int          STAT_SZ_BIT = 18;
    localparam logic [15:0] CYCLES_RST  = 16'h0000;

    typedef enum logic [0:0] {
        RCS_PH_IDLE  = 1'b0,
        RCS_PH_WRITE = 1'b1
    } rcs_phase_t;

    typedef struct packed {
        logic ref_select;
        logic sense_select;
        logic reference_integrator_steer;
        logic sense_integrator_steer;
        logic sample;
        logic integrate;
        logic ref_sample;
        logic sense_sample;
        logic offset_current_subtract;
        logic hard_zero;
        logic squarer_common_return;
    } rcs_sw_ctl_t;

    // after reset the switches show C9, the state ahead of the ring's C0
    localparam rcs_sw_ctl_t SW_RST = 11'h0A3;

    // squarer_common_return: 0 reference_common, 1 sense_low_return
    function automatic rcs_sw_ctl_t rcs_decode(input logic [9:0] st);
        rcs_sw_ctl_t c;
        c = SW_RST;
        c.ref_select   = st[C1] | st[C2] | st[C3];
        c.sense_select = st[C6] | st[C7] | st[C8];
        c.sample       = st[C0] | st[C5];
        c.integrate    = ~(st[C0] | st[C5]);
        c.squarer_common_return = |st[C9:C5];
        c.reference_integrator_steer = c.integrate & ~c.squarer_common_return;
        c.sense_integrator_steer     = c.integrate & c.squarer_common_return;
        c.ref_sample   = c.sample & c.squarer_common_return;
        c.sense_sample = c.sample & ~c.squarer_common_return;
        c.offset_current_subtract = c.ref_select | c.sense_select;
        c.hard_zero    = st[C4] | st[C5] | st[C9] | st[C0];
        return c;
    endfunction : rcs_decode

endpackage : rcs_pkg

// >>> hdl/rcs_sequencer.sv
// rcs_sequencer: mean-square comparator switch sequencer, AHB-Lite slave
// assumes period_tick is a one-cycle pulse synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
// How it works
// - ten states cycle forever, wrapping to first
// - each state lasts one quasi-sinewave period
// - reference half then sense half, five each
// - C1-C3 select reference, steer reference integrator
// - C4 drops select, keeps reference steer
// - subtract during squaring, off in C4
// - C4 applies hard zero to squarer
// - C5 stops integration, sample zeroes squarer
// - C5 strobes reference sample-and-hold
// - common return goes sense low at C5
// - common return reference from C0 on
// - sense half repeats pattern from C6
// - subtraction current changes only at C5
// - error output updates only in C0
// - sense low held C6-C9, back at C0
// - output disable discharges both integrators
// - first integration after enable uses zero subtraction
// - state counter strictly one-hot
// - switches registered together, one period late
// - integrate is inverse of sample
module rcs_sequencer (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    input  wire logic         period_tick,
    output rcs_pkg::rcs_sw_ctl_t switch_ctl,
    output logic              integrator_discharge,
    output logic              amplitude_error_update,
    output logic              subtraction_zero
);

    logic [9:0]           state_q;
    rcs_pkg::rcs_sw_ctl_t sw_d;
    rcs_pkg::rcs_sw_ctl_t sw_q;
    logic                 ctrl_oe_q;
    logic                 ctrl_oe_d;
    logic                 discharge_q;
    logic                 err_upd_q;
    logic                 sub_zero_q;
    logic [15:0]          cycles_q;
    rcs_pkg::rcs_phase_t  phase_q;
    logic [7:0]           wr_addr_q;
    logic [31:0]          hrdata_q;
    logic                 hreadyout_q;
    logic                 hresp_q;
    logic                 bus_valid;
    logic [31:0]          rd_word;

    rcs_state_ring u_ring (
        .hclk    (hclk),
        .hresetn (hresetn),
        .advance (period_tick),
        .state_q (state_q)
    );

    rcs_switch_decode u_decode (
        .state (state_q),
        .sw    (sw_d)
    );

    // all switches move on the same edge, one period after the state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sw_q <= rcs_pkg::SW_RST;
        end
        else if (period_tick)
        begin
            sw_q <= sw_d;
        end
    end

    // integrators held discharged while output is disabled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            discharge_q <= 1'b1;
        end
        else
        begin
            discharge_q <= ~ctrl_oe_q;
        end
    end

    // error output strobe on entry to C0 only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            err_upd_q <= 1'b0;
        end
        else
        begin
            err_upd_q <= period_tick & sw_d.sense_sample & ctrl_oe_q;
        end
    end

    // subtraction held at zero until the first reference sample ends
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sub_zero_q <= 1'b1;
        end
        else if (!ctrl_oe_q)
        begin
            sub_zero_q <= 1'b1;
        end
        else if (period_tick && sw_q.ref_sample)
        begin
            sub_zero_q <= 1'b0;
        end
    end

    // completed comparison cycles
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cycles_q <= rcs_pkg::CYCLES_RST;
        end
        else if (period_tick && state_q[rcs_pkg::C9])
        begin
            cycles_q <= cycles_q + 16'h0001;
        end
    end

    assign bus_valid = hsel & htrans[1] & hready;

    // write data phase follows the captured address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q   <= rcs_pkg::RCS_PH_IDLE;
            wr_addr_q <= 8'h00;
        end
        else if (hready)
        begin
            if (bus_valid && hwrite)
            begin
                phase_q   <= rcs_pkg::RCS_PH_WRITE;
                wr_addr_q <= haddr[7:0];
            end
            else
            begin
                phase_q   <= rcs_pkg::RCS_PH_IDLE;
            end
        end
    end

    // value of the control bit after this edge, used for read bypass
    always_comb
    begin
        ctrl_oe_d = ctrl_oe_q;
        case (phase_q)
            rcs_pkg::RCS_PH_WRITE:
            begin
                if (wr_addr_q == rcs_pkg::ADDR_CTRL)
                begin
                    ctrl_oe_d = hwdata[rcs_pkg::CTRL_OE_BIT];
                end
            end
            rcs_pkg::RCS_PH_IDLE:
            begin
                ctrl_oe_d = ctrl_oe_q;
            end
            default:
            begin
                ctrl_oe_d = ctrl_oe_q;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_oe_q <= rcs_pkg::CTRL_OE_RST;
        end
        else
        begin
            ctrl_oe_q <= ctrl_oe_d;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            rcs_pkg::ADDR_CTRL:
            begin
                rd_word[rcs_pkg::CTRL_OE_BIT] = ctrl_oe_d;
            end
            rcs_pkg::ADDR_STATUS:
            begin
                rd_word[9:0] = state_q;
                rd_word[rcs_pkg::STAT_OE_BIT]  = ctrl_oe_q;
                rd_word[rcs_pkg::STAT_DIS_BIT] = discharge_q;
                rd_word[rcs_pkg::STAT_SZ_BIT]  = sub_zero_q;
            end
            rcs_pkg::ADDR_SWITCH:
            begin
                rd_word[10:0] = sw_q;
            end
            rcs_pkg::ADDR_CYCLES:
            begin
                rd_word[15:0] = cycles_q;
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // zero-wait slave: read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (bus_valid && !hwrite)
        begin
            hrdata_q <= rd_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    assign hreadyout              = hreadyout_q;
    assign hresp                  = hresp_q;
    assign hrdata                 = hrdata_q;
    assign switch_ctl             = sw_q;
    assign integrator_discharge   = discharge_q;
    assign amplitude_error_update = err_upd_q;
    assign subtraction_zero       = sub_zero_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_onehot;
        $onehot(state_q);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot");

    property p_wrap;
        period_tick && state_q[rcs_pkg::C9] |=> state_q[rcs_pkg::C0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("ring did not wrap");

    property p_hold;
        !period_tick |=> $stable(state_q) && $stable(sw_q);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved off tick");

    property p_delay;
        period_tick |=> sw_q == rcs_pkg::rcs_decode($past(state_q));
    endproperty
    a_delay: assert property (p_delay) else $error("switches not delayed");

    property p_inv;
        sw_q.integrate != sw_q.sample;
    endproperty
    a_inv: assert property (p_inv) else $error("integrate equals sample");

    property p_ref_sel;
        sw_q.ref_select |-> sw_q.reference_integrator_steer
            && sw_q.offset_current_subtract && !sw_q.squarer_common_return;
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("bad C1-C3 pattern");

    property p_c4;
        period_tick && state_q[rcs_pkg::C4] |=> !sw_q.ref_select
            && sw_q.reference_integrator_steer
            && !sw_q.offset_current_subtract && sw_q.hard_zero;
    endproperty
    a_c4: assert property (p_c4) else $error("bad C4 pattern");

    property p_c5;
        period_tick && state_q[rcs_pkg::C5] |=> sw_q.ref_sample
            && sw_q.squarer_common_return
            && !sw_q.reference_integrator_steer && sw_q.sample;
    endproperty
    a_c5: assert property (p_c5) else $error("bad C5 pattern");

    property p_c0;
        period_tick && state_q[rcs_pkg::C0] |=> !sw_q.squarer_common_return
            && sw_q.sense_sample;
    endproperty
    a_c0: assert property (p_c0) else $error("bad C0 pattern");

    property p_sense;
        period_tick && state_q[rcs_pkg::C6] |=> sw_q.sense_select
            && sw_q.sense_integrator_steer [*1] ##1 sw_q.squarer_common_return;
    endproperty
    a_sense: assert property (p_sense) else $error("bad sense half");

    property p_sub_hold;
        sw_q.ref_sample |-> state_q[rcs_pkg::C6];
    endproperty
    a_sub_hold: assert property (p_sub_hold) else $error("sample off C5");

    property p_err;
        amplitude_error_update |-> sw_q.sense_sample && state_q[rcs_pkg::C1];
    endproperty
    a_err: assert property (p_err) else $error("error update off C0");

    property p_dis;
        !ctrl_oe_q |=> integrator_discharge && subtraction_zero
            && !amplitude_error_update;
    endproperty
    a_dis: assert property (p_dis) else $error("disable not honoured");

    property p_rearm;
        $rose(ctrl_oe_q) |-> subtraction_zero;
    endproperty
    a_rearm: assert property (p_rearm) else $error("subtraction not zero");

endmodule : rcs_sequencer
`default_nettype wire

// >>> hdl/rcs_state_ring.sv
// rcs_state_ring: one-hot ring of the ten comparison states
// assumes advance is a one-cycle pulse per quasi-sinewave period
`timescale 1ns/1ps
`default_nettype none
module rcs_state_ring (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       advance,
    output logic [9:0]      state_q
);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= rcs_pkg::STATE_RST;
        end
        else if (!$onehot(state_q))
        begin
            // recover from a corrupted ring
            state_q <= rcs_pkg::STATE_RST;
        end
        else if (advance)
        begin
            state_q <= {state_q[8:0], state_q[9]};
        end
    end

endmodule : rcs_state_ring
`default_nettype wire

// >>> hdl/rcs_switch_decode.sv
// rcs_switch_decode: switch pattern of the state held by the ring
// assumes a one-hot state vector
`timescale 1ns/1ps
`default_nettype none
module rcs_switch_decode (
    input  wire logic [9:0]       state,
    output rcs_pkg::rcs_sw_ctl_t  sw
);

    always_comb
    begin
        sw = rcs_pkg::rcs_decode(state);
    end

endmodule : rcs_switch_decode
`default_nettype wire

// >>> test/rcs_analog_model.sv
// rcs_analog_model: behavioural integrators and sample-and-holds
// assumes switch controls and strobes from the sequencer, sampled on hclk
`timescale 1ns/1ps
`default_nettype none
module rcs_analog_model #(
    parameter logic [15:0] REF_STEP = 16'h0010,
    parameter logic [15:0] SNS_STEP = 16'h000C
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire rcs_pkg::rcs_sw_ctl_t sw,
    input  wire logic                 discharge,
    input  wire logic                 err_update,
    input  wire logic                 sub_zero,
    output logic [15:0]               err_level
);
    logic [15:0] ref_q;
    logic [15:0] sns_q;
    logic [15:0] sub_q;
    logic [15:0] hold_q;
    logic [15:0] sub_now;

    assign sub_now = sub_zero ? 16'h0000 : sub_q;
    always_ff @(posedge hclk)
    begin
        if (!hresetn || discharge)
        begin
            ref_q     <= 16'h0000;
            sns_q     <= 16'h0000;
            sub_q     <= 16'h0000;
            hold_q    <= 16'h0000;
            err_level <= 16'h0000;
        end
        else
        begin
            if (sw.reference_integrator_steer && sw.ref_select)
                ref_q <= ref_q + REF_STEP - sub_now;
            if (sw.sense_integrator_steer && sw.sense_select)
                sns_q <= sns_q + SNS_STEP - sub_now;
            if (sw.ref_sample)
                sub_q <= ref_q;
            if (sw.sense_sample)
                hold_q <= sns_q;
            if (err_update)
                err_level <= hold_q;
        end
    end
endmodule : rcs_analog_model
`default_nettype wire

// >>> test/tb_rcs_sequencer.sv
// tb_rcs_sequencer: self-checking bench for the comparator sequencer
// assumes a 50 MHz hclk and the analog model on the switch outputs
`timescale 1ns/1ps
`default_nettype none
module tb_rcs_sequencer;
    logic                 hclk;
    logic                 hresetn;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [2:0]           hsize;
    logic [31:0]          hwdata;
    logic                 hreadyout;
    logic [31:0]          hrdata;
    logic                 hresp;
    logic                 period_tick;
    rcs_pkg::rcs_sw_ctl_t switch_ctl;
    logic                 integrator_discharge;
    logic                 amplitude_error_update;
    logic                 subtraction_zero;
    logic [15:0]          err_level;
    rcs_pkg::rcs_sw_ctl_t sw_e;
    logic                 upd_e;
    logic                 sz_e;
    logic                 en;
    logic                 pt;
    logic [15:0]          r;
    logic [31:0]          rd;
    int                   st;
    int                   cyc_e;
    int                   compares;
    int                   miscompares;

    rcs_sequencer rcs_sequencer_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .period_tick(period_tick), .switch_ctl(switch_ctl),
        .integrator_discharge(integrator_discharge),
        .amplitude_error_update(amplitude_error_update),
        .subtraction_zero(subtraction_zero)
    );
    rcs_analog_model rcs_analog_model_inst (
        .hclk(hclk), .hresetn(hresetn), .sw(switch_ctl),
        .discharge(integrator_discharge), .err_update(amplitude_error_update),
        .sub_zero(subtraction_zero), .err_level(err_level)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // switch pattern of state k
    function automatic rcs_pkg::rcs_sw_ctl_t exp_sw(input int k);
        rcs_pkg::rcs_sw_ctl_t e;
        e = '0;
        e.ref_select = (k >= 1 && k <= 3);
        e.sense_select = (k >= 6 && k <= 8);
        e.reference_integrator_steer = (k >= 1 && k <= 4);
        e.sense_integrator_steer = (k >= 6);
        e.sample = (k == 0 || k == 5);
        e.integrate = !e.sample;
        e.ref_sample = (k == 5);
        e.sense_sample = (k == 0);
        e.offset_current_subtract = e.ref_select || e.sense_select;
        e.hard_zero = (k == 4 || k == 5 || k == 9 || k == 0);
        e.squarer_common_return = (k >= 5);
        return e;
    endfunction : exp_sw

    task automatic chk_bit(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH t=%0t flag got %b exp %b", $time, g, e);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_sw(input rcs_pkg::rcs_sw_ctl_t g, input rcs_pkg::rcs_sw_ctl_t e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH t=%0t switches got %h exp %h", $time, g, e);
        end
    endtask : chk_sw

    task automatic close_out;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge hclk);
        end
        if (n == 50)
            miscompares++;
    endtask : wait_ready

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        chk_bit(hresp, 1'b0);
    endtask : ahb

    // one hclk cycle; tick launched now is taken at the next edge
    task automatic step(input logic t);
        @(posedge hclk);
        upd_e = 1'b0;
        if (pt)
        begin
            sw_e = exp_sw(st);
            upd_e = en && (st == 0);
            if (en && st == 6)
                sz_e = 1'b0;
            if (st == 9)
                cyc_e++;
            st = (st + 1) % 10;
        end
        period_tick <= t;
        pt = t;
        @(negedge hclk);
        chk_sw(switch_ctl, sw_e);
        chk_bit(amplitude_error_update, upd_e);
        chk_bit(subtraction_zero, sz_e);
        chk_bit(integrator_discharge, !en);
    endtask : step

    task automatic set_oe(input logic v);
        step(1'b0);
        ahb(1'b1, 32'(rcs_pkg::ADDR_CTRL), {r[15:1], 16'h0000, v});
        en = v;
        if (!v)
            sz_e = 1'b1;
        step(1'b0);
        ahb(1'b0, 32'(rcs_pkg::ADDR_CTRL), 32'h00000000);
        chk_bit(rd[0], v);
        step(1'b0);
    endtask : set_oe

    task automatic run(input int n, input logic all);
        repeat (n)
        begin
            r = lfsr(r);
            step(all | (r[0] & r[3]));
        end
        step(1'b0);
        ahb(1'b0, 32'(rcs_pkg::ADDR_STATUS), 32'h00000000);
        chk_word(rd, {13'h0000, sz_e, !en, en, 6'h00, 10'(1 << st)});
        ahb(1'b0, 32'(rcs_pkg::ADDR_SWITCH), 32'h00000000);
        chk_word(rd, {21'h000000, sw_e});
        ahb(1'b0, 32'(rcs_pkg::ADDR_CYCLES), 32'h00000000);
        chk_word(rd, 32'(cyc_e));
    endtask : run

    initial
    begin
        hclk = 1'b0;
        forever
            #10 hclk = ~hclk;
    end

    initial
    begin
        #100000;
        miscompares++;
        close_out();
    end

    initial
    begin
        {hsel, haddr, htrans, hwrite, hwdata, period_tick, pt, en, upd_e} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        sw_e = exp_sw(9);
        sz_e = 1'b1;
        st = 0;
        cyc_e = 0;
        compares = 0;
        miscompares = 0;
        r = 16'h835A;
        repeat (8) @(posedge hclk);
        chk_sw(switch_ctl, exp_sw(9));
        chk_bit(integrator_discharge, 1'b1);
        chk_bit(hreadyout, 1'b1);
        hresetn <= 1'b1;
        step(1'b0);
        ahb(1'b1, 32'(rcs_pkg::ADDR_STATUS), 32'hFFFFFFFF);
        run(0, 1'b0);
        ahb(1'b0, 32'h00000010 + {r[3:0], 2'h0}, 32'h00000000);
        chk_word(rd, 32'h00000000);
        $display("test reset and map done");
        run(40, 1'b0);
        $display("test disabled ring done");
        set_oe(1'b1);
        run(150, 1'b0);
        $display("test random ticks done");
        set_oe(1'b0);
        chk_word({16'h0000, err_level}, 32'h00000000);
        run(17, 1'b0);
        set_oe(1'b1);
        run(60, 1'b0);
        $display("test disable and enable done");
        run(33, 1'b1);
        $display("test back to back ticks done");
        close_out();
    end
endmodule : tb_rcs_sequencer
`default_nettype wire
